/* File: hw/agen_pkg.sv */
// Package with constants for the operand address generator
package agen_pkg;
  // ****************************************
  // Register map
  // ****************************************
  localparam logic [2:0]  ADDR_CIRC_CTRL = 3'h0;
  localparam logic [2:0]  ADDR_X_START   = 3'h1;
  localparam logic [2:0]  ADDR_X_END     = 3'h2;
  localparam logic [2:0]  ADDR_Y_START   = 3'h3;
  localparam logic [2:0]  ADDR_Y_END     = 3'h4;
  localparam logic [2:0]  ADDR_STATUS    = 3'h5;
  localparam logic [15:0] CTRL_RESET     = 16'h00FF;
  localparam logic [15:0] BOUND_RESET    = 16'h0000;
  // ****************************************
  // Field positions
  // ****************************************
  localparam int X_SEL_LSB  = 0;
  localparam int Y_SEL_LSB  = 4;
  localparam int X_EN_BIT   = 15;
  localparam int Y_EN_BIT   = 14;
  localparam logic [3:0] SEL_OFF = 4'hF;
  // ****************************************
  // Widths and limits
  // ****************************************
  localparam int FILE_AW  = 13;
  localparam int LIT5_W   = 5;
  localparam int LIT10_W  = 10;
  localparam int LIT14_W  = 14;
  localparam int NREGS    = 16;
  localparam logic [3:0] DSP_X0 = 4'h8;
  localparam logic [3:0] DSP_X1 = 4'h9;
  localparam logic [3:0] DSP_Y0 = 4'hA;
  localparam logic [3:0] DSP_Y1 = 4'hB;
  localparam logic [15:0] MAX_LEN_BYTES = 16'hFFFF;
  // ****************************************
  // Addressing modes
  // ****************************************
  typedef enum logic [3:0] {
    M_FILE, M_REG, M_IND, M_POST, M_PRE, M_INDEX, M_LITOFF,
    M_LIT5, M_LIT10, M_BRANCH, M_HOLD, M_DSP
  } mode_e;
endpackage

/* File: hw/circ_wrap.sv */
// Circular buffer boundary check and wrap for one data space
`timescale 1ns/1ps
module circ_wrap (
  input  wire logic        active,
  input  wire logic        word_only,
  input  wire logic [15:0] start_addr,
  input  wire logic [15:0] end_addr,
  input  wire logic [15:0] base,
  input  wire logic [15:0] raw,
  output logic      [15:0] result,
  output logic             wrapped
);
  logic [16:0] len;
  logic        up;
  logic        over;
  logic        under;
  logic [15:0] fixed;
  logic [15:0] raw_w;
  // Length counts the end byte pair, so end is inclusive
  assign len   = {1'b0, end_addr} - {1'b0, start_addr} + 17'h0_0002;
  assign raw_w = word_only ? {raw[15:1], 1'b0} : raw;
  assign up    = (raw_w >= base);
  // Checks both bounds so power-of-two buffers run either way
  assign over  = up && (raw_w > end_addr);    // RULE_16 RULE_21
  assign under = !up && (raw_w < start_addr); // RULE_16 RULE_21
  // Overshoot is kept: wrap by length preserves position
  assign fixed = over ? raw_w - len[15:0] : raw_w + len[15:0]; // RULE_23
  assign wrapped = active && (over || under);
  assign result  = wrapped ? fixed : raw_w;
endmodule

/* File: hw/operand_address_generation.sv */
// Effective-address generation with X and Y circular buffers
//
// Implementation choices: strobed register access and the register addresses.
`timescale 1ns/1ps
// Summary of operation
// RULE_01 - File address: 13 bits, lowest 8192 bytes
// RULE_02 - Implied register is W0, result there or file
// RULE_03 - First source register direct; second reg/mem/lit5
// RULE_04 - Indirect uses pointer unmodified
// RULE_05 - Post-modify: use pointer then adjust
// RULE_06 - Pre-modify: add signed constant, use result
// RULE_07 - Indexed: pointer plus offset register
// RULE_08 - Literal offset: pointer plus literal
// RULE_09 - Moves share one 4-bit offset field
// RULE_10 - MCU literals are 5 or 10 bits
// RULE_11 - DSP uses W8-W11; 8/9 X, 10/11 Y
// RULE_12 - DSP indexed only on W9 and W11
// RULE_13 - DSP: indirect, indexed, post-modify 2/4/6
// RULE_14 - Branch 16-bit signed; hold 14-bit unsigned
// RULE_15 - One circular buffer per X and Y
// RULE_16 - Power-of-two buffers checked both bounds
// RULE_17 - 16-bit start/end; length up to 32K words
// RULE_18 - Y circular addresses are word aligned
// RULE_19 - X circular needs select not 15 and enable
// RULE_20 - Y circular needs select not 15 and enable
// RULE_21 - Check at or past bound, overshoot corrected
// RULE_22 - Write back only on pre/post modify
// RULE_23 - Wrap by length keeping overshoot
module operand_address_generation (
  input  wire logic        mclk,
  input  wire logic        rst,
  input  wire logic        ce,
  input  wire logic [2:0]  reg_addr,
  input  wire logic [15:0] reg_wdata,
  input  wire logic        reg_wr,
  input  wire logic        reg_rd,
  output logic      [15:0] reg_rdata,
  input  wire logic        op_valid,
  input  wire logic [3:0]  op_mode,
  input  wire logic [3:0]  pointer_reg,
  input  wire logic [3:0]  base_operand_reg,
  input  wire logic [15:0] op_literal,
  input  wire logic        op_dec,
  input  wire logic [2:0]  op_step,
  input  wire logic        op_use_w0,
  input  wire logic [3:0]  wr_sel,
  input  wire logic [15:0] wr_data,
  input  wire logic        wr_en,
  output logic      [15:0] effective_addr,
  output logic      [15:0] operand_value,
  output logic             addr_is_mem,
  output logic             addr_y_space,
  output logic             op_error,
  output logic             addr_valid
);
  // ****************************************
  // Register file and circular control
  // ****************************************
  logic [15:0] default_working_reg_r [agen_pkg::NREGS];
  logic [15:0] ctrl_r;
  logic [15:0] xs_r;
  logic [15:0] xe_r;
  logic [15:0] ys_r;
  logic [15:0] ye_r;
  logic [15:0] wrap_cnt_r;

  wire  [3:0]  x_pointer_select  = ctrl_r[agen_pkg::X_SEL_LSB +: 4];
  wire  [3:0]  y_pointer_select  = ctrl_r[agen_pkg::Y_SEL_LSB +: 4];
  wire         x_circular_enable = ctrl_r[agen_pkg::X_EN_BIT];
  wire         y_circular_enable = ctrl_r[agen_pkg::Y_EN_BIT];

  function automatic logic sel_on(input logic [3:0] sel, input logic en);
    sel_on = en && (sel != agen_pkg::SEL_OFF);
  endfunction

  // ****************************************
  // Operand decode
  // ****************************************
  wire  [3:0]  ptr_idx   = op_use_w0 ? 4'h0 : pointer_reg;       // RULE_02
  wire  [15:0] ptr_val   = default_working_reg_r[ptr_idx];
  wire  [15:0] offs_val  = default_working_reg_r[base_operand_reg];             // RULE_09
  wire  [15:0] step_mag  = {12'h000, op_step, 1'b0};
  wire  [15:0] step_sgn  = op_dec ? (16'h0000 - step_mag) : step_mag;
  wire         m_post    = (op_mode == agen_pkg::M_POST);
  wire         m_pre     = (op_mode == agen_pkg::M_PRE);
  wire         m_dsp     = (op_mode == agen_pkg::M_DSP);
  wire         dsp_reg   = (pointer_reg >= agen_pkg::DSP_X0) &&
                           (pointer_reg <= agen_pkg::DSP_Y1);
  wire         dsp_y     = (pointer_reg == agen_pkg::DSP_Y0) ||
                           (pointer_reg == agen_pkg::DSP_Y1);   // RULE_11
  wire         dsp_idx   = op_use_w0;
  wire         dsp_idx_ok = (pointer_reg == agen_pkg::DSP_X1) ||
                            (pointer_reg == agen_pkg::DSP_Y1);  // RULE_12
  wire         dsp_step_ok = (op_step == 3'h0) || (op_step == 3'h1) ||
                             (op_step == 3'h2) || (op_step == 3'h3); // RULE_13
  wire         dsp_bad   = m_dsp && (!dsp_reg || (dsp_idx && !dsp_idx_ok) ||
                           (!dsp_idx && !dsp_step_ok));
  wire  [15:0] dsp_base  = default_working_reg_r[pointer_reg];
  wire  [15:0] dsp_raw   = dsp_idx ? dsp_base + offs_val : dsp_base; // RULE_12

  logic [15:0] raw_ea;
  logic [15:0] wb_val;
  logic        is_mem;
  always_comb begin
    raw_ea = 16'h0000;
    wb_val = ptr_val;
    is_mem = 1'b1;
    case (op_mode)
      agen_pkg::M_FILE:   raw_ea = {3'b000, op_literal[agen_pkg::FILE_AW-1:0]}; // RULE_01
      agen_pkg::M_REG: begin
        raw_ea = ptr_val;                                        // RULE_03
        is_mem = 1'b0;
      end
      agen_pkg::M_IND:    raw_ea = ptr_val;                      // RULE_04
      agen_pkg::M_POST: begin
        raw_ea = ptr_val;                                        // RULE_05
        wb_val = ptr_val + step_sgn;
      end
      agen_pkg::M_PRE: begin
        raw_ea = ptr_val + step_sgn;                             // RULE_06
        wb_val = raw_ea;
      end
      agen_pkg::M_INDEX:  raw_ea = ptr_val + offs_val;           // RULE_07
      agen_pkg::M_LITOFF: raw_ea = ptr_val + op_literal;         // RULE_08
      agen_pkg::M_LIT5: begin
        raw_ea = {11'h000, op_literal[agen_pkg::LIT5_W-1:0]};    // RULE_03 RULE_10
        is_mem = 1'b0;
      end
      agen_pkg::M_LIT10: begin
        raw_ea = {6'h00, op_literal[agen_pkg::LIT10_W-1:0]};     // RULE_10
        is_mem = 1'b0;
      end
      agen_pkg::M_BRANCH: begin
        raw_ea = op_literal;                                     // RULE_14
        is_mem = 1'b0;
      end
      agen_pkg::M_HOLD: begin
        raw_ea = {2'b00, op_literal[agen_pkg::LIT14_W-1:0]};     // RULE_14
        is_mem = 1'b0;
      end
      agen_pkg::M_DSP: begin
        raw_ea = dsp_raw;                                        // RULE_13
        wb_val = dsp_idx ? dsp_base : dsp_base + step_sgn;
      end
      default: begin
        raw_ea = 16'h0000;
        is_mem = 1'b0;
      end
    endcase
  end

  // ****************************************
  // Circular correction, one per space
  // ****************************************
  wire [3:0] circ_idx = m_dsp ? pointer_reg : ptr_idx;
  wire       circ_mode = is_mem && (op_mode != agen_pkg::M_FILE);
  wire       x_act = circ_mode && !(m_dsp && dsp_y) &&
                     sel_on(x_pointer_select, x_circular_enable) &&
                     (circ_idx == x_pointer_select);             // RULE_15 RULE_19
  wire       y_act = circ_mode && m_dsp && dsp_y &&
                     sel_on(y_pointer_select, y_circular_enable) &&
                     (circ_idx == y_pointer_select);             // RULE_15 RULE_20
  wire       post_like = m_post || (m_dsp && !dsp_idx);
  wire [15:0] ea_base = post_like ? ptr_val : (m_dsp ? dsp_base : ptr_val);
  wire [15:0] mod_raw = post_like ? wb_val : raw_ea;
  wire [15:0] x_res;
  wire [15:0] y_res;
  wire        x_wrap;
  wire        y_wrap;

  circ_wrap u_xwrap (
    .active     (x_act),
    .word_only  (1'b0),
    .start_addr (xs_r),
    .end_addr   (xe_r),
    .base       (ea_base),
    .raw        (mod_raw),
    .result     (x_res),
    .wrapped    (x_wrap)
  );
  circ_wrap u_ywrap (
    .active     (y_act),
    .word_only  (1'b1),                                          // RULE_18
    .start_addr (ys_r),
    .end_addr   (ye_r),
    .base       (dsp_base),
    .raw        (mod_raw),
    .result     (y_res),
    .wrapped    (y_wrap)
  );

  wire [15:0] mod_res  = y_act ? y_res : x_res;
  wire        any_act  = x_act || y_act;
  wire        any_wrap = x_wrap || y_wrap;
  wire [15:0] ea_nxt   = (any_act && !post_like) ? mod_res :
                         (m_dsp ? dsp_raw : raw_ea);             // RULE_22
  // Pre-modify keeps the corrected pointer too, else the next access starts outside
  wire [15:0] wb_nxt   = (any_act && (post_like || m_pre)) ? mod_res : wb_val; // RULE_22
  wire        do_wb    = op_valid && !dsp_bad && (m_post || m_pre ||
                         (m_dsp && !dsp_idx));                   // RULE_22
  wire [3:0]  wb_idx   = m_dsp ? pointer_reg : ptr_idx;
  wire [15:0] val_nxt  = (op_mode == agen_pkg::M_REG) ? ptr_val : raw_ea;
  wire        ea_ok    = !dsp_bad;

  // ****************************************
  // Register bus decode
  // ****************************************
  wire wr_ctrl = reg_wr && (reg_addr == agen_pkg::ADDR_CIRC_CTRL);
  wire wr_xs   = reg_wr && (reg_addr == agen_pkg::ADDR_X_START);  // RULE_17
  wire wr_xe   = reg_wr && (reg_addr == agen_pkg::ADDR_X_END);
  wire wr_ys   = reg_wr && (reg_addr == agen_pkg::ADDR_Y_START);
  wire wr_ye   = reg_wr && (reg_addr == agen_pkg::ADDR_Y_END);
  logic [15:0] rd_mux;
  always_comb begin
    case (reg_addr)
      agen_pkg::ADDR_CIRC_CTRL: rd_mux = ctrl_r;
      agen_pkg::ADDR_X_START:   rd_mux = xs_r;
      agen_pkg::ADDR_X_END:     rd_mux = xe_r;
      agen_pkg::ADDR_Y_START:   rd_mux = ys_r;
      agen_pkg::ADDR_Y_END:     rd_mux = ye_r;
      agen_pkg::ADDR_STATUS:    rd_mux = wrap_cnt_r;
      default:                  rd_mux = 16'h0000;
    endcase
  end

  // ****************************************
  // State
  // ****************************************
  always_ff @(posedge mclk) begin
    if (rst) begin
      ctrl_r     <= agen_pkg::CTRL_RESET;
      xs_r       <= agen_pkg::BOUND_RESET;
      xe_r       <= agen_pkg::BOUND_RESET;
      ys_r       <= agen_pkg::BOUND_RESET;
      ye_r       <= agen_pkg::BOUND_RESET;
      reg_rdata  <= 16'h0000;
      wrap_cnt_r <= 16'h0000;
    end else if (ce) begin
      if (wr_ctrl) ctrl_r <= reg_wdata;
      if (wr_xs) xs_r <= reg_wdata;
      if (wr_xe) xe_r <= reg_wdata;
      if (wr_ys) ys_r <= {reg_wdata[15:1], 1'b0};               // RULE_18
      if (wr_ye) ye_r <= {reg_wdata[15:1], 1'b0};
      reg_rdata <= reg_rd ? rd_mux : 16'h0000;
      if (op_valid && !dsp_bad && any_wrap) wrap_cnt_r <= wrap_cnt_r + 16'h0001;
    end
  end

  // Decoder writes lose to address write-back on the same register
  for (genvar i = 0; i < agen_pkg::NREGS; i++) begin : g_default_working_reg
    always_ff @(posedge mclk) begin
      if (rst) begin
        default_working_reg_r[i] <= 16'h0000;
      end else if (ce) begin
        if (do_wb && (wb_idx == 4'(i))) default_working_reg_r[i] <= wb_nxt;     // RULE_05 RULE_06
        else if (wr_en && (wr_sel == 4'(i))) default_working_reg_r[i] <= wr_data;
      end
    end
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      effective_addr <= 16'h0000;
      operand_value  <= 16'h0000;
      addr_is_mem    <= 1'b0;
      addr_y_space   <= 1'b0;
      op_error       <= 1'b0;
      addr_valid     <= 1'b0;
    end else if (ce) begin
      effective_addr <= ea_nxt;
      operand_value  <= val_nxt;
      addr_is_mem    <= op_valid && is_mem && ea_ok;
      addr_y_space   <= op_valid && m_dsp && dsp_y;              // RULE_11
      op_error       <= op_valid && dsp_bad;
      addr_valid     <= op_valid && ea_ok;
    end
  end

  // ****************************************
  // Checks
  // ****************************************
  AST_FILE_RANGE: assert property (@(posedge mclk) disable iff (rst) // RULE_01
    (ce && op_valid && op_mode == agen_pkg::M_FILE) |=> effective_addr[15:13] == 3'b000)
    else $error("File address beyond near space");
  AST_POST_USE: assert property (@(posedge mclk) disable iff (rst) // RULE_05
    (ce && op_valid && m_post && !any_act && !wr_en) |=>
    effective_addr == $past(ptr_val))
    else $error("Post-modify did not use old pointer");
  AST_PRE_USE: assert property (@(posedge mclk) disable iff (rst) // RULE_06
    (ce && op_valid && m_pre && !any_act) |=>
    effective_addr == $past(ptr_val) + $past(step_sgn))
    else $error("Pre-modify address wrong");
  AST_INDEX: assert property (@(posedge mclk) disable iff (rst) // RULE_07
    (ce && op_valid && op_mode == agen_pkg::M_INDEX && !any_act) |=>
    effective_addr == $past(ptr_val) + $past(offs_val))
    else $error("Indexed address wrong");
  AST_DSP_IDX: assert property (@(posedge mclk) disable iff (rst) // RULE_12
    (ce && op_valid && m_dsp && dsp_idx && !dsp_idx_ok) |=> op_error)
    else $error("DSP index on wrong register not flagged");
  AST_DSP_Y: assert property (@(posedge mclk) disable iff (rst) // RULE_11
    (ce && op_valid && m_dsp && pointer_reg == agen_pkg::DSP_X0) |=> !addr_y_space)
    else $error("W8 routed to Y space");
  AST_X_OFF: assert property (@(posedge mclk) disable iff (rst) // RULE_19
    (x_pointer_select == agen_pkg::SEL_OFF || !x_circular_enable) |-> !x_act)
    else $error("X circular active while disabled");
  AST_Y_OFF: assert property (@(posedge mclk) disable iff (rst) // RULE_20
    (y_pointer_select == agen_pkg::SEL_OFF || !y_circular_enable) |-> !y_act)
    else $error("Y circular active while disabled");
  AST_Y_ALIGN: assert property (@(posedge mclk) disable iff (rst) // RULE_18
    (ce && op_valid && y_act && !post_like) |=> !effective_addr[0])
    else $error("Y circular address odd");
  AST_NO_WB: assert property (@(posedge mclk) disable iff (rst) // RULE_22
    (ce && op_valid && op_mode == agen_pkg::M_LITOFF && !wr_en) |=>
    default_working_reg_r[$past(ptr_idx)] == $past(ptr_val))
    else $error("Offset mode changed pointer");
  AST_PRE_WB: assert property (@(posedge mclk) disable iff (rst) // RULE_22
    (ce && op_valid && m_pre) |=> default_working_reg_r[$past(ptr_idx)] == effective_addr)
    else $error("Pre-modify pointer differs from address used");
  AST_Y_WB_ALIGN: assert property (@(posedge mclk) disable iff (rst) // RULE_18
    (ce && op_valid && y_act && post_like && !dsp_bad) |=>
    !default_working_reg_r[$past(pointer_reg)][0])
    else $error("Y circular pointer left odd");
  AST_DSP_STEP: assert property (@(posedge mclk) disable iff (rst) // RULE_13
    (ce && op_valid && m_dsp && !op_use_w0 && op_step > 3'h3) |=> op_error)
    else $error("DSP step above six bytes not flagged");
  AST_ERR_NO_WB: assert property (@(posedge mclk) disable iff (rst) // RULE_11
    (ce && op_valid && dsp_bad && !wr_en) |=>
    default_working_reg_r[$past(pointer_reg)] == $past(dsp_base))
    else $error("Refused DSP request moved its pointer");
  AST_LIT5: assert property (@(posedge mclk) disable iff (rst) // RULE_10
    (ce && op_valid && op_mode == agen_pkg::M_LIT5) |=> operand_value[15:5] == 11'h000)
    else $error("Short literal wider than five bits");
  AST_LIT10: assert property (@(posedge mclk) disable iff (rst) // RULE_10
    (ce && op_valid && op_mode == agen_pkg::M_LIT10) |=> operand_value[15:10] == 6'h00)
    else $error("Long literal wider than ten bits");
  AST_HOLD_LIT: assert property (@(posedge mclk) disable iff (rst) // RULE_14
    (ce && op_valid && op_mode == agen_pkg::M_HOLD) |=> operand_value[15:14] == 2'b00)
    else $error("Hold literal wider than fourteen bits");
  AST_BRANCH_LIT: assert property (@(posedge mclk) disable iff (rst) // RULE_14
    (ce && op_valid && op_mode == agen_pkg::M_BRANCH) |=> operand_value == $past(op_literal))
    else $error("Branch literal not passed whole");
  // Clock enable low must freeze results, not only stop new requests
  AST_CE_HOLD: assert property (@(posedge mclk) disable iff (rst)
    (!ce) |=> $stable(effective_addr) && $stable(addr_valid))
    else $error("Outputs moved while clock enable low");
endmodule

/* File: tb/decoder_model.sv */
// Instruction decoder model that issues operand requests and W register writes
`timescale 1ns/1ps
module decoder_model (
  input  wire logic        mclk,
  output logic             op_valid,
  output logic [3:0]       op_mode,
  output logic [3:0]       pointer_reg,
  output logic [3:0]       base_operand_reg,
  output logic [15:0]      op_literal,
  output logic             op_dec,
  output logic [2:0]       op_step,
  output logic             op_use_w0,
  output logic [3:0]       wr_sel,
  output logic [15:0]      wr_data,
  output logic             wr_en
);
  // ****************************************
  // Drivers, all launched just after a rising edge
  // ****************************************
  initial begin
    {op_valid, op_mode, pointer_reg, base_operand_reg, op_literal} = '0;
    {op_dec, op_step, op_use_w0, wr_sel, wr_data, wr_en} = '0;
  end
  task automatic issue(input logic [3:0] m, input logic [3:0] p, input logic [15:0] lit,
                       input logic dn, input logic [2:0] st, input logic w0);
    @(posedge mclk);
    op_valid         <= 1'b1;
    op_mode          <= m;
    pointer_reg      <= p;
    base_operand_reg <= 4'h3;
    op_literal       <= lit;
    op_dec           <= dn;
    op_step          <= st;
    op_use_w0        <= w0;
    wr_en            <= 1'b0;
  endtask
  task automatic wr_w(input logic [3:0] s, input logic [15:0] d);
    @(posedge mclk);
    op_valid <= 1'b0;
    wr_en    <= 1'b1;
    wr_sel   <= s;
    wr_data  <= d;
  endtask
  // Idle literal keeps toggling so a stale field is never mistaken for a live one
  task automatic idle();
    @(posedge mclk);
    op_valid   <= 1'b0;
    wr_en      <= 1'b0;
    op_literal <= ~op_literal;
  endtask
endmodule

/* File: tb/tb_top.sv */
// Self-checking bench for the operand address generator
`timescale 1ns/1ps
module tb_top;
  typedef struct {logic [15:0] v; logic err; logic y; logic isv;} note_s;
  logic mclk, rst, ce, reg_wr, reg_rd, op_valid, op_dec, op_use_w0, wr_en;
  logic [2:0] reg_addr, op_step;
  logic [3:0] op_mode, pointer_reg, base_operand_reg, wr_sel;
  logic [15:0] reg_wdata, reg_rdata, op_literal, wr_data, effective_addr, operand_value;
  logic addr_is_mem, addr_y_space, op_error, addr_valid, rd_d;
  note_s oq[$];
  logic [15:0] rq[$];
  note_s n;
  integer errors = 0, total_checks = 0, cycles = 0, seed, i;
  logic [31:0] r;
  always #25 mclk = ~mclk;
  operand_address_generation dut (.mclk(mclk), .rst(rst), .ce(ce), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .op_valid(op_valid), .op_mode(op_mode), .pointer_reg(pointer_reg),
    .base_operand_reg(base_operand_reg), .op_literal(op_literal), .op_dec(op_dec),
    .op_step(op_step), .op_use_w0(op_use_w0), .wr_sel(wr_sel), .wr_data(wr_data),
    .wr_en(wr_en), .effective_addr(effective_addr), .operand_value(operand_value),
    .addr_is_mem(addr_is_mem), .addr_y_space(addr_y_space), .op_error(op_error),
    .addr_valid(addr_valid));
  decoder_model dm (.mclk(mclk), .op_valid(op_valid), .op_mode(op_mode),
    .pointer_reg(pointer_reg), .base_operand_reg(base_operand_reg), .op_literal(op_literal),
    .op_dec(op_dec), .op_step(op_step), .op_use_w0(op_use_w0), .wr_sel(wr_sel),
    .wr_data(wr_data), .wr_en(wr_en));
  // ****************************************
  // Compare, report and close
  // ****************************************
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    total_checks++;
    if (seen !== exp) begin
      errors++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic give_verdict();
    $display("errors=%0d total_checks=%0d", errors, total_checks);
    if (errors == 0 && total_checks > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask
  // ****************************************
  // Register bus and operand requests
  // ****************************************
  task automatic reg_write(input logic [2:0] a, input logic [15:0] d);
    @(posedge mclk);
    reg_wr    <= 1'b1;
    reg_addr  <= a;
    reg_wdata <= d;
    @(posedge mclk);
    reg_wr <= 1'b0;
  endtask
  task automatic reg_read(input logic [2:0] a, input logic [15:0] exp);
    rq.push_back(exp);
    @(posedge mclk);
    reg_rd   <= 1'b1;
    reg_addr <= a;
    @(posedge mclk);
    reg_rd <= 1'b0;
  endtask
  task automatic op(input agen_pkg::mode_e m, input logic [3:0] p, input logic [15:0] lit,
                    input logic dn, input logic [2:0] st, input logic [15:0] v,
                    input logic err = 1'b0, input logic y = 1'b0, input logic w0 = 1'b0,
                    input logic isv = 1'b0);
    oq.push_back('{v, err, y, isv});
    dm.issue(m, p, lit, dn, st, w0);
  endtask
  // ****************************************
  // Result watcher: oldest note against each result
  // ****************************************
  always @(posedge mclk) rd_d <= reg_rd;
  always @(negedge mclk) begin
    if (rd_d === 1'b1) begin
      check(reg_rdata, rq.pop_front());
    end
    if (addr_valid === 1'b1 || op_error === 1'b1) begin
      n = oq.pop_front();
      check({15'h0, op_error}, {15'h0, n.err});
      if (n.err === 1'b0) begin
        check(n.isv ? operand_value : effective_addr, n.v);
        check({15'h0, addr_y_space}, {15'h0, n.y});
        check({15'h0, addr_is_mem}, {15'h0, !n.isv});
      end
    end
  end
  // Ceiling well above the ~110 cycles the sequence needs
  always @(posedge mclk) begin
    cycles++;
    if (cycles == 3000) begin
      errors++;
      give_verdict();
    end
  end
  initial begin
    {mclk, reg_addr, reg_wdata, reg_wr, reg_rd} = '0;
    rst  = 1'b1;
    ce   = 1'b1;
    seed = 11;
    repeat (12) @(posedge mclk);
    rst <= 1'b0;
    reg_read(agen_pkg::ADDR_CIRC_CTRL, agen_pkg::CTRL_RESET);
    reg_read(agen_pkg::ADDR_X_END, agen_pkg::BOUND_RESET);
    reg_write(3'h6, 16'hFFFF);
    reg_read(3'h6, 16'h0000);
    reg_read(3'h7, 16'h0000);
    reg_write(agen_pkg::ADDR_X_START, 16'h2000);
    reg_write(agen_pkg::ADDR_X_END, 16'h2006);
    reg_write(agen_pkg::ADDR_Y_START, 16'h3001);
    reg_write(agen_pkg::ADDR_Y_END, 16'h3007);
    reg_read(agen_pkg::ADDR_Y_START, 16'h3000);
    reg_read(agen_pkg::ADDR_X_END, 16'h2006);
    reg_write(agen_pkg::ADDR_CIRC_CTRL, 16'hC0A4);
    reg_read(agen_pkg::ADDR_CIRC_CTRL, 16'hC0A4);
    dm.wr_w(4'h0, 16'h0300);
    dm.wr_w(4'h2, 16'h1000);
    dm.wr_w(4'h3, 16'h0010);
    dm.wr_w(4'h4, 16'h2006);
    dm.wr_w(4'h8, 16'h0500);
    dm.wr_w(4'h9, 16'h0100);
    dm.wr_w(4'hA, 16'h3006);
    op(agen_pkg::M_FILE, 4'h0, 16'hFFFF, 1'b0, 3'h0, 16'h1FFF);
    op(agen_pkg::M_IND, 4'h5, 16'h0, 1'b0, 3'h0, 16'h0300, 0, 0, 1);
    op(agen_pkg::M_IND, 4'h2, 16'h0, 1'b0, 3'h0, 16'h1000);
    op(agen_pkg::M_REG, 4'h3, 16'h0, 1'b0, 3'h0, 16'h0010, 0, 0, 0, 1);
    op(agen_pkg::M_POST, 4'h2, 16'h0, 1'b0, 3'h1, 16'h1000);
    op(agen_pkg::M_PRE, 4'h2, 16'h0, 1'b1, 3'h2, 16'h0FFE);
    op(agen_pkg::M_INDEX, 4'h2, 16'h0, 1'b0, 3'h0, 16'h100E);
    op(agen_pkg::M_LITOFF, 4'h2, 16'h0020, 1'b0, 3'h0, 16'h101E);
    op(agen_pkg::M_LIT5, 4'h0, 16'hFFFF, 1'b0, 3'h0, 16'h001F, 0, 0, 0, 1);
    op(agen_pkg::M_LIT10, 4'h0, 16'hFFFF, 1'b0, 3'h0, 16'h03FF, 0, 0, 0, 1);
    op(agen_pkg::M_BRANCH, 4'h0, 16'h8001, 1'b0, 3'h0, 16'h8001, 0, 0, 0, 1);
    op(agen_pkg::M_HOLD, 4'h0, 16'hFFFF, 1'b0, 3'h0, 16'h3FFF, 0, 0, 0, 1);
    op(agen_pkg::M_DSP, 4'h8, 16'h0, 1'b0, 3'h2, 16'h0500);
    op(agen_pkg::M_DSP, 4'h8, 16'h0, 1'b0, 3'h0, 16'h0504);
    op(agen_pkg::M_DSP, 4'h9, 16'h0, 1'b0, 3'h0, 16'h0110, 0, 0, 1);
    op(agen_pkg::M_DSP, 4'hA, 16'h0, 1'b0, 3'h1, 16'h3006, 0, 1);
    op(agen_pkg::M_DSP, 4'hA, 16'h0, 1'b0, 3'h0, 16'h3000, 0, 1);
    op(agen_pkg::M_DSP, 4'h5, 16'h0, 1'b0, 3'h0, 16'h0, 1);
    op(agen_pkg::M_DSP, 4'h8, 16'h0, 1'b0, 3'h0, 16'h0, 1, 0, 1);
    op(agen_pkg::M_DSP, 4'h9, 16'h0, 1'b0, 3'h4, 16'h0, 1);
    op(agen_pkg::M_POST, 4'h4, 16'h0, 1'b0, 3'h1, 16'h2006);
    op(agen_pkg::M_IND, 4'h4, 16'h0, 1'b0, 3'h0, 16'h2000);
    op(agen_pkg::M_PRE, 4'h4, 16'h0, 1'b1, 3'h1, 16'h2006);
    op(agen_pkg::M_IND, 4'h4, 16'h0, 1'b0, 3'h0, 16'h2006);
    op(agen_pkg::M_PRE, 4'h4, 16'h0, 1'b0, 3'h3, 16'h2004);
    op(agen_pkg::M_LITOFF, 4'h4, 16'h0006, 1'b0, 3'h0, 16'h2002);
    op(agen_pkg::M_IND, 4'h4, 16'h0, 1'b0, 3'h0, 16'h2004);
    dm.idle();
    reg_write(agen_pkg::ADDR_CIRC_CTRL, 16'h00F4);
    ce <= 1'b0;
    reg_write(agen_pkg::ADDR_X_START, 16'h1234);
    dm.wr_w(4'h2, 16'h1111);
    dm.idle();
    ce <= 1'b1;
    reg_read(agen_pkg::ADDR_X_START, 16'h2000);
    op(agen_pkg::M_IND, 4'h2, 16'h0, 1'b0, 3'h0, 16'h0FFE);
    dm.wr_w(4'h4, 16'h2006);
    op(agen_pkg::M_POST, 4'h4, 16'h0, 1'b0, 3'h1, 16'h2006);
    op(agen_pkg::M_IND, 4'h4, 16'h0, 1'b0, 3'h0, 16'h2008);
    for (i = 0; i < 8; i++) begin
      r = $random(seed);
      dm.wr_w(4'h6, {r[15:1], 1'b0});
      op(agen_pkg::M_IND, 4'h6, r[31:16], 1'b0, 3'h0, {r[15:1], 1'b0});
    end
    dm.idle();
    reg_read(agen_pkg::ADDR_STATUS, 16'h0005);
    repeat (3) @(posedge mclk);
    check(16'(oq.size() + rq.size()), 16'h0000);
    give_verdict();
  end
endmodule
